// >>> core/tuner_params.svh
// Register offsets, field positions, reset values and bus codes of the tuner control block
`ifndef TUNER_PARAMS_SVH
`define TUNER_PARAMS_SVH

`define ADDR_W            8
`define BAND_SEL_OFS      8'h00
`define SERIES_CAP_OFS    8'h04
`define PARALLEL_CAP_OFS  8'h08
`define STATUS_OFS        8'h0C
`define ROM_INDEX_OFS     8'h10
`define READBACK_OFS      8'h14
`define OVLD_TRIM_OFS     8'h18
`define VCO_OFS           8'h1C
`define IRQ_STAT_OFS      8'h20
`define IRQ_MASK_OFS      8'h24
`define REG_PTR_OFS       8'h28
`define DATA_PORT_OFS     8'h2C

`define STATUS_POR_BIT    7
`define STATUS_LOCK_MSB   6
`define STATUS_LOCK_LSB   4
`define VCO_SEL_MSB       6
`define VCO_SEL_LSB       5
`define VCO_SUB_MSB       4
`define VCO_SUB_LSB       2
`define VCO_DIV_MSB       1
`define VCO_DIV_LSB       0

`define BAND_RST          2'h0
`define SERIES_CAP_RST    8'h00
`define PARALLEL_CAP_RST  6'h00
`define OVLD_TRIM_RST     3'h0
`define VCO_SEL_RST       2'h0
`define VCO_SUB_RST       3'h0
`define VCO_DIV_RST       2'h0
`define IRQ_STAT_RST      4'h1
`define IRQ_MASK_RST      4'h0
`define POST_DIV_BASE     6'h04
`define VCO_SEL_RSVD      2'h3
`define LOCK_LOW_CODE     3'h0
`define LOCK_HIGH_CODE    3'h7

`define ROM_DEPTH         16
`define ROM_AW            4
`define ROM_INIT          128'h0000_0000_0000_0080_8080_8080_8080_8080

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// >>> core/tuner_pkg.sv
// Shared types of the tuner control block
package tuner_pkg;

  typedef enum logic [1:0] {
    BAND_LOW_LPF,
    BAND_LOW,
    BAND_HIGH,
    BAND_RSVD
  } band_code_e;

  typedef struct packed {
    logic low_band_rf_input;
    logic low_band_lowpass;
    logic high_band_rf_input;
  } band_route_s;

  typedef struct packed {
    logic [1:0] vco_select;
    logic [2:0] vco_sub_band;
    logic [1:0] vco_post_divider;
  } vco_cfg_s;

  typedef struct packed {
    logic unlock_high;
    logic unlock_low;
    logic lock_gain;
    logic power_on;
  } irq_bits_s;

endpackage

// >>> core/calib_rom.sv
// Factory calibration ROM with registered read data
`timescale 1ns/10ps
`include "tuner_params.svh"
module calib_rom #(
  parameter int                 DEPTH   = `ROM_DEPTH,
  parameter int                 AW      = `ROM_AW,
  parameter logic [DEPTH*8-1:0] CONTENT = `ROM_INIT
) (
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  input  wire logic          rd_en_i,
  input  wire logic [AW-1:0] addr_i,
  output logic      [7:0]    data_o
);

  logic [7:0] data_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_q <= 8'h00;
    end else if (ce_i && rd_en_i) begin
      data_q <= CONTENT[addr_i*8 +: 8];
    end
  end

  assign data_o = data_q;

endmodule

// >>> core/tuner_config_calib_regs.sv
// Tuner control and calibration registers behind an AXI4-Lite slave
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "tuner_params.svh"
module tuner_config_calib_regs
  import tuner_pkg::*;
#(
  parameter logic [`ROM_DEPTH*8-1:0] ROM_CONTENT = `ROM_INIT
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic [2:0]        lock_window_code_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [`ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [`ADDR_W-1:0] s_axi_araddr_i,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output band_route_s            band_route_o,
  output logic [7:0]             series_cap_code_o,
  output logic [5:0]             parallel_cap_code_o,
  output logic [2:0]             overload_trim_o,
  output vco_cfg_s               vco_cfg_o,
  output logic [5:0]             post_div_ratio_o,
  output logic                   irq_o
);

  logic              aw_held_q, awready_q, w_held_q, wready_q, bvalid_q;
  logic              ar_held_q, arready_q, rvalid_q, wstrb0_q, load_q;
  logic [`ADDR_W-1:0] awaddr_q, araddr_q;
  logic [7:0]        wdata_q, rdata_q;
  logic [1:0]        bresp_q, rresp_q;
  band_code_e        band_code_q;
  band_route_s       band_route_q;
  logic [7:0]        series_q, readback_q;
  logic [5:0]        parallel_q, post_div_q;
  logic [2:0]        trim_q, lock_s1_q, lock_s2_q, lock_prev_q;
  logic [3:0]        rom_index_q, ptr_q, irq_mask_q;
  vco_cfg_s          vco_q;
  irq_bits_s         irq_stat_q, irq_ev, irq_stat_d;
  logic              por_q, irq_q;
  logic [7:0]        rom_data;

  // Handshakes
  wire aw_take = ce_i & s_axi_awvalid_i & awready_q;
  wire w_take  = ce_i & s_axi_wvalid_i & wready_q;
  wire ar_take = ce_i & s_axi_arvalid_i & arready_q;
  wire wr_fire = ce_i & aw_held_q & w_held_q & ~bvalid_q;
  wire b_done  = ce_i & bvalid_q & s_axi_bready_i;
  wire r_done  = ce_i & rvalid_q & s_axi_rready_i;

  // Effective register address, data port redirected through the pointer
  wire       wr_port = awaddr_q == `DATA_PORT_OFS;
  wire       rd_port = araddr_q == `DATA_PORT_OFS;
  wire [7:0] ptr_adr = {2'h0, ptr_q, 2'h0};
  wire [7:0] wr_eff  = wr_port ? ptr_adr : awaddr_q;
  wire [7:0] rd_eff  = rd_port ? ptr_adr : araddr_q;
  wire       wr_map  = (wr_eff[1:0] == 2'h0) && (wr_port ? wr_eff < `REG_PTR_OFS : wr_eff <= `DATA_PORT_OFS);
  wire       rd_map  = (rd_eff[1:0] == 2'h0) && (rd_port ? rd_eff < `REG_PTR_OFS : rd_eff <= `DATA_PORT_OFS);
  wire       wr_en   = wr_fire & wr_map & wstrb0_q;

  wire wr_band   = wr_en && wr_eff == `BAND_SEL_OFS;
  wire wr_series = wr_en && wr_eff == `SERIES_CAP_OFS;
  wire wr_par    = wr_en && wr_eff == `PARALLEL_CAP_OFS;
  wire wr_index  = wr_en && wr_eff == `ROM_INDEX_OFS;
  wire wr_trim   = wr_en && wr_eff == `OVLD_TRIM_OFS;
  wire wr_vco    = wr_en && wr_eff == `VCO_OFS;
  wire wr_mask   = wr_en && wr_eff == `IRQ_MASK_OFS;
  wire wr_ptr    = wr_en && wr_eff == `REG_PTR_OFS;

  // Reads wait while a ROM fetch is in flight so readback is never stale
  wire rd_fire   = ce_i & ar_held_q & ~rvalid_q & ~wr_fire & ~load_q;
  wire rd_status = rd_fire && rd_map && rd_eff == `STATUS_OFS;
  wire rd_irq    = rd_fire && rd_map && rd_eff == `IRQ_STAT_OFS;
  wire ptr_step  = (wr_fire & wr_port) | (rd_fire & rd_port);

  wire [2:0] lock_code = lock_s2_q;
  wire [7:0] status_byte = {por_q, lock_code, 4'h0};
  wire [7:0] rd_byte =
    (rd_eff == `BAND_SEL_OFS)     ? {6'h00, band_code_q} :
    (rd_eff == `SERIES_CAP_OFS)   ? series_q :
    (rd_eff == `PARALLEL_CAP_OFS) ? {2'h0, parallel_q} :
    (rd_eff == `STATUS_OFS)       ? status_byte :
    (rd_eff == `ROM_INDEX_OFS)    ? {4'h0, rom_index_q} :
    (rd_eff == `READBACK_OFS)     ? readback_q :
    (rd_eff == `OVLD_TRIM_OFS)    ? {5'h00, trim_q} :
    (rd_eff == `VCO_OFS)          ? {1'b0, vco_q} :
    (rd_eff == `IRQ_STAT_OFS)     ? {4'h0, irq_stat_q} :
    (rd_eff == `IRQ_MASK_OFS)     ? {4'h0, irq_mask_q} :
    (rd_eff == `REG_PTR_OFS)      ? {4'h0, ptr_q} : 8'h00;

  // Band decode; the reserved code never reaches the registers
  wire [1:0] wr_band_code = wdata_q[1:0];
  wire       band_legal   = wr_band_code != 2'h3;
  wire band_route_s band_dec = (wr_band_code == 2'h0) ? 3'b110 :
                               (wr_band_code == 2'h1) ? 3'b100 : 3'b001;
  wire [1:0] vco_sel_new  = wdata_q[`VCO_SEL_MSB:`VCO_SEL_LSB];
  wire [1:0] vco_div_new  = wdata_q[`VCO_DIV_MSB:`VCO_DIV_LSB];

  // Lock window events
  wire locked_now  = lock_code != `LOCK_LOW_CODE && lock_code != `LOCK_HIGH_CODE;
  wire locked_prev = lock_prev_q != `LOCK_LOW_CODE && lock_prev_q != `LOCK_HIGH_CODE;
  assign irq_ev.power_on    = 1'b0;
  assign irq_ev.lock_gain   = locked_now & ~locked_prev;
  assign irq_ev.unlock_low  = lock_code == `LOCK_LOW_CODE && lock_prev_q != `LOCK_LOW_CODE;
  assign irq_ev.unlock_high = lock_code == `LOCK_HIGH_CODE && lock_prev_q != `LOCK_HIGH_CODE;
  assign irq_stat_d = (rd_irq ? 4'h0 : irq_stat_q) | irq_ev;

  calib_rom #(
    .DEPTH   (`ROM_DEPTH),
    .AW      (`ROM_AW),
    .CONTENT (ROM_CONTENT)
  ) u_rom (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .rd_en_i   (wr_index),
    .addr_i    (wdata_q[3:0]),
    .data_o    (rom_data)
  );

  // Write channel
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_q <= 1'b0;
      awready_q <= 1'b1;
      awaddr_q  <= 8'h00;
      w_held_q  <= 1'b0;
      wready_q  <= 1'b1;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
        awready_q <= 1'b1;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata_i[7:0];
        wstrb0_q <= s_axi_wstrb_i[0];
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
        wready_q <= 1'b1;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (b_done) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ar_held_q <= 1'b0;
      arready_q <= 1'b1;
      araddr_q  <= 8'h00;
      rvalid_q  <= 1'b0;
      rdata_q   <= 8'h00;
      rresp_q   <= `RESP_OKAY;
    end else begin
      if (ar_take) begin
        ar_held_q <= 1'b1;
        arready_q <= 1'b0;
        araddr_q  <= s_axi_araddr_i;
      end else if (rd_fire) begin
        ar_held_q <= 1'b0;
        arready_q <= 1'b1;
      end
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_map ? rd_byte : 8'h00;
        rresp_q  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (r_done) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Tuning configuration
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      band_code_q  <= band_code_e'(`BAND_RST);
      band_route_q <= 3'b110;
      series_q     <= `SERIES_CAP_RST;
      parallel_q   <= `PARALLEL_CAP_RST;
      trim_q       <= `OVLD_TRIM_RST;
      vco_q        <= {`VCO_SEL_RST, `VCO_SUB_RST, `VCO_DIV_RST};
      post_div_q   <= `POST_DIV_BASE;
    end else begin
      if (wr_band && band_legal) begin
        band_code_q  <= band_code_e'(wr_band_code);
        band_route_q <= band_dec;
      end
      if (wr_series) series_q <= wdata_q;
      if (wr_par) parallel_q <= wdata_q[5:0];
      if (wr_trim) trim_q <= wdata_q[2:0];
      if (wr_vco) begin
        vco_q.vco_sub_band     <= wdata_q[`VCO_SUB_MSB:`VCO_SUB_LSB];
        vco_q.vco_post_divider <= vco_div_new;
        post_div_q             <= `POST_DIV_BASE << vco_div_new;
        if (vco_sel_new != `VCO_SEL_RSVD) vco_q.vco_select <= vco_sel_new;
      end
    end
  end

  // ROM fetch, pointer, status and interrupts
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rom_index_q <= 4'h0;
      load_q      <= 1'b0;
      readback_q  <= 8'h00;
      ptr_q       <= 4'h0;
      por_q       <= 1'b1;
      lock_s1_q   <= 3'h0;
      lock_s2_q   <= 3'h0;
      lock_prev_q <= 3'h0;
      irq_stat_q  <= `IRQ_STAT_RST;
      irq_mask_q  <= `IRQ_MASK_RST;
      irq_q       <= 1'b0;
    end else if (ce_i) begin
      if (wr_index) rom_index_q <= wdata_q[3:0];
      load_q <= wr_index;
      if (load_q) readback_q <= rom_data;
      if (wr_ptr) ptr_q <= wdata_q[3:0];
      else if (ptr_step) ptr_q <= ptr_q + 4'h1;
      if (rd_status) por_q <= 1'b0;
      lock_s1_q   <= lock_window_code_i;
      lock_s2_q   <= lock_s1_q;
      lock_prev_q <= lock_s2_q;
      irq_stat_q  <= irq_stat_d;
      if (wr_mask) irq_mask_q <= wdata_q[3:0];
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign s_axi_awready_o     = awready_q;
  assign s_axi_wready_o      = wready_q;
  assign s_axi_bvalid_o      = bvalid_q;
  assign s_axi_bresp_o       = bresp_q;
  assign s_axi_arready_o     = arready_q;
  assign s_axi_rvalid_o      = rvalid_q;
  assign s_axi_rdata_o       = {24'h000000, rdata_q};
  assign s_axi_rresp_o       = rresp_q;
  assign band_route_o        = band_route_q;
  assign series_cap_code_o   = series_q;
  assign parallel_cap_code_o = parallel_q;
  assign overload_trim_o     = trim_q;
  assign vco_cfg_o           = vco_q;
  assign post_div_ratio_o    = post_div_q;
  assign irq_o               = irq_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_band_decode: assert property (
    (band_code_q == BAND_LOW_LPF |-> band_route_q == 3'b110) and
    (band_code_q == BAND_LOW |-> band_route_q == 3'b100) and
    (band_code_q == BAND_HIGH |-> band_route_q == 3'b001))
    else $error("band route does not match band code");
  a_band_reserved_keep: assert property (
    wr_band && wr_band_code == 2'h3 |=> $stable(band_code_q) && $stable(band_route_q))
    else $error("reserved band code changed the selection");
  a_series_cap_load: assert property (
    wr_series |=> series_cap_code_o == $past(wdata_q))
    else $error("series code not loaded");
  a_readback_fetch: assert property (
    wr_index |-> ##2 readback_q == ROM_CONTENT[$past(wdata_q[3:0], 2)*8 +: 8])
    else $error("readback does not hold the indexed ROM byte");
  a_read_waits_rom: assert property (
    wr_index |-> ##1 !rd_fire)
    else $error("read served during a ROM fetch");
  a_post_div_ratio: assert property (
    post_div_ratio_o == (`POST_DIV_BASE << vco_cfg_o.vco_post_divider))
    else $error("post divider ratio mismatch");
  a_vco_reserved_keep: assert property (
    wr_vco && vco_sel_new == `VCO_SEL_RSVD |=> $stable(vco_cfg_o.vco_select))
    else $error("reserved VCO selection accepted");
  a_status_layout: assert property (
    rd_status |=> s_axi_rdata_o[3:0] == 4'h0 && s_axi_rdata_o[6:4] == $past(lock_code))
    else $error("status read layout wrong");
  a_por_clear: assert property (
    rd_status |=> !por_q ##1 !por_q)
    else $error("power-on flag not cleared by status read");
  a_ptr_advance: assert property (
    ptr_step && !wr_ptr |=> ptr_q == $past(ptr_q) + 4'h1)
    else $error("register pointer did not advance");
  a_irq_level: assert property (
    ce_i |=> irq_o == |($past(irq_stat_q) & $past(irq_mask_q)))
    else $error("interrupt output does not follow masked status");

  c_rom_read: cover property (wr_index ##[1:20] (rd_fire && rd_eff == `READBACK_OFS));
  c_port_burst: cover property (ptr_step ##[1:20] ptr_step);
  c_lock_gain: cover property (irq_ev.lock_gain);
  c_status_read: cover property (rd_status && por_q);

endmodule

// >>> sim/host_model.sv
// Host processor model: AXI4-Lite master with start-up calibration and lock search
`timescale 1ns/10ps
`include "tuner_params.svh"
module host_model (
  input  wire logic        clk_i,
  output logic             awvalid_o,
  output logic [7:0]       awaddr_o,
  output logic             wvalid_o,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             bready_o,
  output logic             arvalid_o,
  output logic [7:0]       araddr_o,
  output logic             rready_o,
  input  wire logic        awready_i,
  input  wire logic        wready_i,
  input  wire logic        bvalid_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        arready_i,
  input  wire logic        rvalid_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i
);
  int         hangs = 0;
  logic [7:0] rom_copy [0:8];

  initial begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
    {awaddr_o, araddr_o, wdata_o} = '0;
    wstrb_o = 4'hF;
  end

  // Released payload is inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      if (bvalid_i) break;
    end
    r = bresp_i;
    bready_o <= 1'b0;
    if (n == 64) hangs++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      if (rvalid_i) break;
    end
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
    if (n == 64) hangs++;
  endtask

  task automatic power_up();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 9; i++) begin
      wr(`ROM_INDEX_OFS, 32'(i), r);
      rd(`READBACK_OFS, d, r);
      rom_copy[i] = d[7:0];
    end
    wr(`OVLD_TRIM_OFS, {29'h0, rom_copy[0][7:5]}, r);
  endtask

  task automatic search(input logic [2:0] sub, output logic [2:0] got);
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 8; k++) begin
      wr(`VCO_OFS, {25'h0, 2'h1, sub, 2'h2}, r);
      repeat (4) @(posedge clk_i);
      rd(`STATUS_OFS, d, r);
      if (d[6:4] == 3'h7) sub++;
      else if (d[6:4] == 3'h0) sub--;
      else break;
    end
    got = sub;
  endtask

  // Capacitor code from one intercept and slope pair; band scale given in hundredths
  function automatic int cap_code(input int icpt, input int slope, input int scale_m, input int f_mhz);
    return (icpt * 50000 + (slope - 256) * scale_m * f_mhz * 10) / 256000;
  endfunction

  task automatic tune(input int f_mhz, input logic high);
    int         ser;
    int         par;
    logic [1:0] r;
    ser = high ? cap_code(rom_copy[5], rom_copy[6], 5, f_mhz) - 10 : cap_code(rom_copy[1], rom_copy[2], 15, f_mhz);
    par = high ? cap_code(rom_copy[7], rom_copy[8], 5, f_mhz) : cap_code(rom_copy[3], rom_copy[4], 10, f_mhz);
    wr(`SERIES_CAP_OFS, 32'(ser), r);
    wr(`PARALLEL_CAP_OFS, 32'(par), r);
  endtask
endmodule

// >>> sim/tb_tuner_config_calib_regs.sv
// Testbench of the tuner control and calibration registers
`timescale 1ns/10ps
`include "tuner_params.svh"
module tb_tuner_config_calib_regs import tuner_pkg::*;;
  localparam logic [127:0] ROM = 128'h0F0E_0D0C_0B0A_09C8_C7C6_C5C4_C3C2_C1A0;
  localparam logic [1:0]   OK  = `RESP_OKAY;
  localparam logic [1:0]   ERR = `RESP_SLVERR;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [2:0]  lock = 3'h7;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr, cap_s;
  logic [31:0] wdata, rdata, d, s;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  cap_p, ratio;
  logic [2:0]  trim, g;
  logic [2:0]  er = 3'b110;
  band_route_s route;
  vco_cfg_s    vco;
  logic [31:0] seed = 32'hBA9D;
  int          errors = 0;
  int          checked = 0;

  tuner_config_calib_regs #(.ROM_CONTENT(ROM)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .lock_window_code_i(lock),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .band_route_o(route), .series_cap_code_o(cap_s), .parallel_cap_code_o(cap_p),
    .overload_trim_o(trim), .vco_cfg_o(vco), .post_div_ratio_o(ratio), .irq_o(irq)
  );

  host_model host (
    .clk_i(ref_clk_i), .awvalid_o(awvalid), .awaddr_o(awaddr), .wvalid_o(wvalid),
    .wdata_o(wdata), .wstrb_o(wstrb), .bready_o(bready), .arvalid_o(arvalid),
    .araddr_o(araddr), .rready_o(rready), .awready_i(awready), .wready_i(wready),
    .bvalid_i(bvalid), .bresp_i(bresp), .arready_i(arready), .rvalid_i(rvalid),
    .rdata_i(rdata), .rresp_i(rresp)
  );

  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // PLL stand-in: low sub-bands sit at the top of the range, high ones at the bottom
  function automatic logic [2:0] lock_of(input logic [2:0] sb);
    return (sb < 3) ? 3'h7 : (sb > 5) ? 3'h0 : sb;
  endfunction

  function automatic logic [2:0] route_of(input logic [1:0] b, input logic [2:0] prev);
    case (b)
      2'h0: return 3'b110;
      2'h1: return 3'b100;
      2'h2: return 3'b001;
      default: return prev;
    endcase
  endfunction

  always @(posedge ref_clk_i) lock <= lock_of(vco.vco_sub_band);

  // A bus wait that ran out of its bound ends the run at once
  always @(posedge ref_clk_i) if (host.hangs != 0) conclude();

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er_resp);
    host.wr(a, v, r);
    chk(r, er_resp);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er_resp);
    host.rd(a, d, r);
    chk(d, e);
    chk(r, er_resp);
  endtask

  task automatic conclude();
    errors += host.hangs;
    $display("errors %0d, checks %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #2000000;
    errors++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    chk(route, 3'b110);
    chk(ratio, 6'h04);
    chk(irq, 1'b0);
    repeat (4) @(posedge ref_clk_i);
    rdc(`STATUS_OFS, 32'hF0, OK);
    rdc(`STATUS_OFS, 32'h70, OK);
    rdc(`IRQ_STAT_OFS, 32'h9, OK);
    rdc(`IRQ_MASK_OFS, 32'h0, OK);
    for (int b = 0; b < 4; b++) begin
      er = route_of(b[1:0], er);
      wr(`BAND_SEL_OFS, b, OK);
      chk(route, er);
    end
    rdc(`BAND_SEL_OFS, 32'h2, OK);
    repeat (4) begin
      s = xs();
      wr(`SERIES_CAP_OFS, s, OK);
      wr(`PARALLEL_CAP_OFS, s >> 8, OK);
      chk(cap_s, s[7:0]);
      chk(cap_p, s[13:8]);
      rdc(`PARALLEL_CAP_OFS, s[13:8], OK);
    end
    host.power_up();
    for (int i = 0; i < 9; i++) chk(host.rom_copy[i], ROM[i*8 +: 8]);
    chk(trim, ROM[7:5]);
    host.tune(200, 1'b0);
    chk(cap_s, 32'h0000001E);
    chk(cap_p, 32'h00000021);
    host.tune(600, 1'b1);
    chk(cap_s, 32'h00000015);
    chk(cap_p, 32'h00000020);
    wr(`ROM_INDEX_OFS, 32'hF, OK);
    rdc(`READBACK_OFS, ROM[127:120], OK);
    for (int v = 0; v < 4; v++) begin
      s = xs();
      wr(`VCO_OFS, {25'h0, 2'(v), s[4:2], 2'(v)}, OK);
      chk(vco, {((v == 3) ? 2'h2 : 2'(v)), s[4:2], 2'(v)});
      chk(ratio, 6'h04 << v);
    end
    wr(`VCO_OFS, 32'h2C, OK);
    repeat (4) @(posedge ref_clk_i);
    host.rd(`IRQ_STAT_OFS, d, r);
    wr(`IRQ_MASK_OFS, 32'h4, OK);
    host.search(3'h7, g);
    chk(g, 3'h5);
    chk(irq, 1'b1);
    rdc(`IRQ_STAT_OFS, 32'h6, OK);
    repeat (2) @(posedge ref_clk_i);
    chk(irq, 1'b0);
    host.search(3'h0, g);
    chk(g, 3'h3);
    rdc(`IRQ_STAT_OFS, 32'hA, OK);
    s = xs();
    wr(`REG_PTR_OFS, 32'h1, OK);
    wr(`DATA_PORT_OFS, s, OK);
    wr(`DATA_PORT_OFS, s >> 8, OK);
    rdc(`REG_PTR_OFS, 32'h3, OK);
    chk(cap_s, s[7:0]);
    chk(cap_p, s[13:8]);
    wr(`REG_PTR_OFS, 32'h1, OK);
    rdc(`DATA_PORT_OFS, s[7:0], OK);
    rdc(`DATA_PORT_OFS, s[13:8], OK);
    wr(`REG_PTR_OFS, 32'hA, OK);
    wr(`DATA_PORT_OFS, s, ERR);
    rdc(8'h30, 32'h0, ERR);
    wr(8'h30, s, ERR);
    conclude();
  end
endmodule
